// ==== inc/dcr_params.svh ====
// Offsets, field positions, reset values and codes of the converter control bank.
// Assumes a 32-bit APB slave; register index times four gives the byte address.
`ifndef DCR_PARAMS_SVH
`define DCR_PARAMS_SVH

// Register indices, byte address is index * 4
`define DCR_IDX_C2CTL   8'hb7
`define DCR_IDX_C2SEQ   8'hb8
`define DCR_IDX_C3CTL   8'hba
`define DCR_IDX_STAT    8'hc0
`define DCR_IDX_MASK    8'hc1
`define DCR_IDX_SLEEP   8'hc2

// Converter two control fields
`define DCR_C2_TOPO     14
`define DCR_C2_HIBMODE  12
`define DCR_C2_TRIG_HI  9
`define DCR_C2_TRIG_LO  8
`define DCR_C2_ILIM     6
`define DCR_C2_RMPH     4
`define DCR_C2_RMPL     3
`define DCR_C2_FB_HI    1
`define DCR_C2_FB_LO    0
`define DCR_C2CTL_WMASK 16'h535b
`define DCR_C2CTL_RST   16'h0018

// Converter two sequencing fields
`define DCR_SEQ_ACT_HI  15
`define DCR_SEQ_ACT_LO  14
`define DCR_SEQ_EN_HI   13
`define DCR_SEQ_EN_LO   10
`define DCR_SEQ_SD_HI   9
`define DCR_SEQ_SD_LO   6
`define DCR_C2SEQ_WMASK 16'hffc0
`define DCR_C2SEQ_RST   16'h0000

// Converter three control fields
`define DCR_C3_NOOVP    11
`define DCR_C3_FLOAT    10
`define DCR_C3_V_HI     6
`define DCR_C3_V_LO     0
`define DCR_C3CTL_WMASK 16'h0c7f
`define DCR_C3CTL_RST   16'h0000
`define DCR_C3_VMAX     7'h66

// Packed output flops at reset, already decoded from the register defaults
`define DCR_OUTS_RST    12'h330

// Codes
`define DCR_RAMP_LOWV   2'h3
`define DCR_FB_USB      2'h3
`define DCR_SLOT_NEVER  4'h0
`define DCR_SLOT_EDGE   4'hf

// Interrupt status bits
`define DCR_ST_FAULT    0
`define DCR_ST_SLEEP    1
`define DCR_ST_WIDTH    2

`endif

// ==== inc/dcr_pkg.sv ====
// Types of the converter control bank.
// Assumes dcr_params.svh supplies the numeric constants.
package dcr_pkg;

  // Converter two run state
  typedef enum logic {
    DCR_OFF,
    DCR_ON
  } dcr_run_t;

  // Fault reaction codes
  typedef enum logic [1:0] {
    DCR_ACT_IGNORE,
    DCR_ACT_CONV,
    DCR_ACT_SYS,
    DCR_ACT_RSVD
  } dcr_act_t;

endpackage

// ==== core/dcr_sync.sv ====
// Two-flop synchroniser for pin inputs of the converter control bank.
// Assumes core_clk domain; first stage is read only by the second.
`timescale 1ns/1ps
`default_nettype none

module dcr_sync #(
  parameter int WIDTH = 5
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;  // First stage, metastable
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;  // Second stage, safe
  logic [WIDTH-1:0] sync_d;

  // Next values, frozen when disabled
  always_comb begin
    meta_d = clk_en ? async_in : meta_q;
    sync_d = clk_en ? meta_q : sync_q;
  end

  // Two stages
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

`default_nettype wire

// ==== core/dcr_regs.sv ====
// Control bank for converter two (boost/switch) and converter three (buck).
// Assumes an APB master on core_clk, a sequencer on core_clk giving
// slot strobes, and asynchronous pins for low-power, hibernate and fault.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "dcr_params.svh"

module dcr_regs (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  input  wire logic        sm_reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        low_power_input_one,
  input  wire logic        low_power_input_two,
  input  wire logic        low_power_input_three,
  input  wire logic        gpio_sleep_pin,
  input  wire logic        conv2_fault_pin,
  input  wire logic        seq_slot_stb,
  input  wire logic [3:0]  seq_slot,
  input  wire logic        seq_enter_active,
  input  wire logic        seq_enter_off,
  output var  logic        conv2_switch_mode,
  output var  logic        conv2_output_en,
  output var  logic        conv2_sleeping,
  output var  logic        conv2_peak_low,
  output var  logic [1:0]  conv2_ramp,
  output var  logic [1:0]  conv2_feedback_source,
  output var  logic        sys_shutdown_req,
  output var  logic        conv3_ovp_en,
  output var  logic        conv3_discharge_en,
  output var  logic [6:0]  conv3_voltage_code,
  output var  logic        irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Cap a voltage code at the top step
  function automatic logic [6:0] dcr_cap(input logic [15:0] r);
    logic [6:0] v;
    v = r[`DCR_C3_V_HI:`DCR_C3_V_LO];
    dcr_cap = (v > `DCR_C3_VMAX) ? `DCR_C3_VMAX : v;
  endfunction

  // Slot match: codes 1..14 fire on their own slot strobe
  function automatic logic dcr_slot_hit(input logic [3:0] code, input logic stb,
                                        input logic [3:0] slot);
    dcr_slot_hit = stb && (code != `DCR_SLOT_NEVER) && (code != `DCR_SLOT_EDGE)
                   && (code == slot);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [4:0] pins_s;  // lp1, lp2, lp3, gpio, fault

  dcr_sync #(.WIDTH(5)) u_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .async_in ({conv2_fault_pin, gpio_sleep_pin, low_power_input_three,
                low_power_input_two, low_power_input_one}),
    .sync_out (pins_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB register file

  logic [15:0] c2ctl_q, c2ctl_d;     // Converter two control
  logic [15:0] c2seq_q, c2seq_d;     // Converter two sequencing
  logic [15:0] c3ctl_q, c3ctl_d;     // Converter three control
  logic [`DCR_ST_WIDTH-1:0] stat_q, stat_d;  // Sticky events
  logic [`DCR_ST_WIDTH-1:0] mask_q, mask_d;  // Interrupt enables
  logic        sleep_q, sleep_d;     // Software hibernate request
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic [`DCR_ST_WIDTH-1:0] events;  // From converter logic
  logic        wr_hit, rd_hit, setup;
  logic [7:0]  idx;                  // Word index
  logic        mapped;

  assign idx    = paddr[9:2];
  assign setup  = psel && !penable && !pready_q;
  assign wr_hit = psel && penable && pready_q && pwrite && mapped;
  assign rd_hit = psel && penable && pready_q && !pwrite;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
                  (idx == `DCR_IDX_C2CTL || idx == `DCR_IDX_C2SEQ ||
                   idx == `DCR_IDX_C3CTL || idx == `DCR_IDX_STAT ||
                   idx == `DCR_IDX_MASK || idx == `DCR_IDX_SLEEP);

  // Bus and register next values
  always_comb begin
    c2ctl_d   = c2ctl_q;
    c2seq_d   = c2seq_q;
    c3ctl_d   = c3ctl_q;
    mask_d    = mask_q;
    sleep_d   = sleep_q;
    stat_d    = stat_q;
    prdata_d  = prdata_q;
    pready_d  = setup;            // No wait state, answer ready in the first access cycle
    pslverr_d = setup ? !mapped : pslverr_q;
    if (setup) begin
      // Capture read data at setup; nothing else changes it meanwhile
      // Refused addresses read zero, whatever their index bits hold
      case (mapped ? idx : 8'h00)
        `DCR_IDX_C2CTL: prdata_d = {16'h0000, c2ctl_q};
        `DCR_IDX_C2SEQ: prdata_d = {16'h0000, c2seq_q};
        `DCR_IDX_C3CTL: prdata_d = {16'h0000, c3ctl_q};
        `DCR_IDX_STAT:  prdata_d = {30'h0, stat_q | events};
        `DCR_IDX_MASK:  prdata_d = {30'h0, mask_q};
        `DCR_IDX_SLEEP: prdata_d = {31'h0, sleep_q};
        default:        prdata_d = 32'h0000_0000;
      endcase
    end
    // Read clears status at the access edge
    if (rd_hit && mapped && idx == `DCR_IDX_STAT) begin
      stat_d = '0;
    end
    if (wr_hit) begin
      case (idx)
        `DCR_IDX_C2CTL: c2ctl_d = pwdata[15:0] & `DCR_C2CTL_WMASK;
        `DCR_IDX_C2SEQ: c2seq_d = pwdata[15:0] & `DCR_C2SEQ_WMASK;
        `DCR_IDX_C3CTL: c3ctl_d = pwdata[15:0] & `DCR_C3CTL_WMASK;
        `DCR_IDX_MASK:  mask_d  = pwdata[`DCR_ST_WIDTH-1:0];
        `DCR_IDX_SLEEP: sleep_d = pwdata[0];
        default:        ;
      endcase
    end
    // New events win over the clear
    stat_d = stat_d | events;
    // Power state machine reset restores the three control register defaults
    if (sm_reset) begin
      c2ctl_d = `DCR_C2CTL_RST;
      c2seq_d = `DCR_C2SEQ_RST;
      c3ctl_d = `DCR_C3CTL_RST;
    end
  end

  // Register file flops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      c2ctl_q   <= `DCR_C2CTL_RST;
      c2seq_q   <= `DCR_C2SEQ_RST;
      c3ctl_q   <= `DCR_C3CTL_RST;
      stat_q    <= '0;
      mask_q    <= '0;
      sleep_q   <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (clk_en) begin
      c2ctl_q   <= c2ctl_d;
      c2seq_q   <= c2seq_d;
      c3ctl_q   <= c3ctl_d;
      stat_q    <= stat_d;
      mask_q    <= mask_d;
      sleep_q   <= sleep_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Converter two run control and outputs

  dcr_pkg::dcr_run_t run_q, run_d;   // Converter two state
  dcr_pkg::dcr_act_t act;
  logic        trig, hib, fault_q, fault_rise, hib_q;
  logic        sysd_q, sysd_d;
  logic        out_d;
  logic [1:0]  ramp_d;
  logic [3:0]  en_code, sd_code;
  logic [11:0] outs_q, outs_d;       // Packed static outputs

  assign act     = dcr_pkg::dcr_act_t'(c2seq_q[`DCR_SEQ_ACT_HI:`DCR_SEQ_ACT_LO]);
  assign en_code = c2seq_q[`DCR_SEQ_EN_HI:`DCR_SEQ_EN_LO];
  assign sd_code = c2seq_q[`DCR_SEQ_SD_HI:`DCR_SEQ_SD_LO];
  assign fault_rise = pins_s[4] && !fault_q;

  // Hibernate trigger select plus pin override
  always_comb begin
    case (c2ctl_q[`DCR_C2_TRIG_HI:`DCR_C2_TRIG_LO])
      2'h0:    trig = sleep_q;
      2'h1:    trig = pins_s[0];
      2'h2:    trig = pins_s[1];
      2'h3:    trig = pins_s[2];
      default: trig = sleep_q;
    endcase
    hib = trig || pins_s[3];
  end

  // Events for the status register
  assign events = {hib && !hib_q, fault_rise};

  // Sequencing and fault reaction
  always_comb begin
    run_d  = run_q;
    sysd_d = sysd_q;
    case (run_q)
      dcr_pkg::DCR_OFF: begin
        if (dcr_slot_hit(en_code, seq_slot_stb, seq_slot) ||
            (en_code == `DCR_SLOT_EDGE && seq_enter_active)) begin
          run_d = dcr_pkg::DCR_ON;
        end
      end
      dcr_pkg::DCR_ON: begin
        if (dcr_slot_hit(sd_code, seq_slot_stb, seq_slot) ||
            ((sd_code == `DCR_SLOT_NEVER || sd_code == `DCR_SLOT_EDGE) &&
             seq_enter_off)) begin
          run_d = dcr_pkg::DCR_OFF;
        end
      end
      default: run_d = dcr_pkg::DCR_OFF;
    endcase
    // Off entry serves a pending request; a fault in that cycle still wins
    if (seq_enter_off) begin
      sysd_d = 1'b0;
    end
    // Fault reaction in the same cycle as the status event
    if (fault_rise) begin
      case (act)
        dcr_pkg::DCR_ACT_IGNORE: ;
        dcr_pkg::DCR_ACT_CONV:   run_d = dcr_pkg::DCR_OFF;
        default:                 sysd_d = 1'b1;  // Reserved acts as system
      endcase
    end
    if (sm_reset) begin
      run_d  = dcr_pkg::DCR_OFF;
      sysd_d = 1'b0;
    end
  end

  // Packed outputs decoded from the fields, the next run state, hibernate and interrupt status
  always_comb begin
    // Feedback from the USB divider forces the low-voltage ramp
    if (c2ctl_q[`DCR_C2_FB_HI:`DCR_C2_FB_LO] == `DCR_FB_USB) begin
      ramp_d = `DCR_RAMP_LOWV;
    end else begin
      ramp_d = {c2ctl_q[`DCR_C2_RMPH], c2ctl_q[`DCR_C2_RMPL]};
    end
    // Output on while running unless hibernate set to disable
    out_d = (run_d == dcr_pkg::DCR_ON) &&
            !(hib && c2ctl_q[`DCR_C2_HIBMODE]);
    outs_d = {c2ctl_q[`DCR_C2_TOPO],
              c2ctl_q[`DCR_C2_ILIM],
              ramp_d,
              c2ctl_q[`DCR_C2_FB_HI:`DCR_C2_FB_LO],
              !c3ctl_q[`DCR_C3_NOOVP],
              !c3ctl_q[`DCR_C3_FLOAT],
              out_d, hib, |(stat_q & mask_q), 1'b0};
  end

  // Run state and output flops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q   <= dcr_pkg::DCR_OFF;
      sysd_q  <= 1'b0;
      fault_q <= 1'b0;
      hib_q   <= 1'b0;
      outs_q  <= `DCR_OUTS_RST;  // Match the decoded defaults, no jump on release
      conv3_voltage_code <= 7'h00;
    end else if (clk_en) begin
      run_q   <= run_d;
      sysd_q  <= sysd_d;
      fault_q <= pins_s[4];
      hib_q   <= hib;
      outs_q  <= outs_d;
      conv3_voltage_code <= dcr_cap(c3ctl_q);
    end
  end

  assign conv2_switch_mode     = outs_q[11];
  assign conv2_peak_low        = outs_q[10];
  assign conv2_ramp            = outs_q[9:8];
  assign conv2_feedback_source = outs_q[7:6];
  assign conv3_ovp_en          = outs_q[5];
  assign conv3_discharge_en    = outs_q[4];
  assign conv2_output_en       = outs_q[3];
  assign conv2_sleeping        = outs_q[2];
  assign irq                   = outs_q[1];
  assign sys_shutdown_req      = sysd_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence fb_usb_s;
    clk_en && c2ctl_q[1:0] == 2'h3;
  endsequence

  ramp_force_a: assert property (fb_usb_s |=> conv2_ramp == 2'h3)
    else $error("ramp not forced to low-voltage code");
  ramp_pass_a: assert property (clk_en && c2ctl_q[1:0] != 2'h3
    |=> conv2_ramp == $past(c2ctl_q[4:3]))
    else $error("ramp does not follow its bits");
  topo_sel_a: assert property (clk_en |=> conv2_switch_mode == $past(c2ctl_q[14]))
    else $error("topology output wrong");
  pin_hib_a: assert property (clk_en && pins_s[3] |=> conv2_sleeping)
    else $error("hibernate pin ignored");
  hib_off_a: assert property (clk_en && hib && c2ctl_q[12] |=> !conv2_output_en)
    else $error("output kept on in hibernate");
  volt_cap_a: assert property (conv3_voltage_code <= 7'h66)
    else $error("voltage code above cap");
  sm_rst_a: assert property (clk_en && sm_reset
    |=> c2ctl_q == 16'h0018 && c2seq_q == 16'h0000 && c3ctl_q == 16'h0000)
    else $error("state machine reset left fields");
  fault_conv_a: assert property (clk_en && fault_rise && act == dcr_pkg::DCR_ACT_CONV
    ##0 !sm_reset |=> run_q == dcr_pkg::DCR_OFF && !conv2_output_en)
    else $error("fault did not stop converter");
  fault_sys_a: assert property (clk_en && fault_rise && act[1] && !sm_reset
    |=> sys_shutdown_req)
    else $error("fault did not request shutdown");
  start_slot_a: assert property (clk_en && run_q == dcr_pkg::DCR_OFF && !sm_reset
    && !fault_rise && dcr_slot_hit(en_code, seq_slot_stb, seq_slot)
    |=> run_q == dcr_pkg::DCR_ON)
    else $error("startup slot missed");
  never_start_a: assert property (clk_en && en_code == 4'h0 && run_q == dcr_pkg::DCR_OFF
    |=> run_q == dcr_pkg::DCR_OFF)
    else $error("converter started with slot zero");
  sd_off_a: assert property (clk_en && run_q == dcr_pkg::DCR_ON && seq_enter_off
    && (sd_code == 4'h0 || sd_code == 4'hf) |=> run_q == dcr_pkg::DCR_OFF)
    else $error("no shutdown on entering off");
  ovp_sel_a: assert property (clk_en |=> conv3_ovp_en == !$past(c3ctl_q[11]))
    else $error("overvoltage enable wrong");
  float_sel_a: assert property (clk_en |=> conv3_discharge_en == !$past(c3ctl_q[10]))
    else $error("discharge enable wrong");

endmodule

`default_nettype wire

// ==== sim/dcr_regs_tb_top.sv ====
// Self-checking bench for the converter control bank: APB tasks plus
// sequencer, pin and fault stimulus, checked at the block's outputs.
// Assumes dcr_params.svh on the include path and dcr_regs compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "dcr_params.svh"

`define CHK(nm, e, g) \
  begin \
    comparisons++; \
    if ((g) !== (e)) begin \
      fails++; \
      $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
    end \
  end

module dcr_regs_tb_top;

  ////////////////////////////////////////////////////////////////////////////////
  // Signals
  logic        core_clk;                // 250 MHz
  logic        arst_n;                  // Async reset, low active
  logic        clk_en;                  // Held high, freeze path not exercised
  logic        sm_reset;                // State machine reset
  logic        psel;                    // APB request
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:1]  lp;                      // Low-power inputs one to three
  logic        gpio_sleep_pin;
  logic        conv2_fault_pin;
  logic        seq_slot_stb;
  logic [3:0]  seq_slot;
  logic        seq_enter_active;
  logic        seq_enter_off;
  logic        conv2_switch_mode;
  logic        conv2_output_en;
  logic        conv2_sleeping;
  logic        conv2_peak_low;
  logic [1:0]  conv2_ramp;
  logic [1:0]  conv2_feedback_source;
  logic        sys_shutdown_req;
  logic        conv3_ovp_en;
  logic        conv3_discharge_en;
  logic [6:0]  conv3_voltage_code;
  logic        irq;
  int          fails       = 0;         // Mismatch count
  int          comparisons = 0;         // Comparison count
  int          r;                       // Loop indices
  int          f;
  logic [1:0]  er;                      // Expected ramp

  // Byte addresses, index times four
  localparam logic [11:0] A_C2CTL = {2'h0, `DCR_IDX_C2CTL, 2'h0};
  localparam logic [11:0] A_C2SEQ = {2'h0, `DCR_IDX_C2SEQ, 2'h0};
  localparam logic [11:0] A_C3CTL = {2'h0, `DCR_IDX_C3CTL, 2'h0};
  localparam logic [11:0] A_STAT  = {2'h0, `DCR_IDX_STAT, 2'h0};
  localparam logic [11:0] A_MASK  = {2'h0, `DCR_IDX_MASK, 2'h0};
  localparam logic [11:0] A_SLEEP = {2'h0, `DCR_IDX_SLEEP, 2'h0};

  ////////////////////////////////////////////////////////////////////////////////
  // Device under test
  dcr_regs u_dut (
    .core_clk              (core_clk),
    .arst_n                (arst_n),
    .clk_en                (clk_en),
    .sm_reset              (sm_reset),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .low_power_input_one   (lp[1]),
    .low_power_input_two   (lp[2]),
    .low_power_input_three (lp[3]),
    .gpio_sleep_pin        (gpio_sleep_pin),
    .conv2_fault_pin       (conv2_fault_pin),
    .seq_slot_stb          (seq_slot_stb),
    .seq_slot              (seq_slot),
    .seq_enter_active      (seq_enter_active),
    .seq_enter_off         (seq_enter_off),
    .conv2_switch_mode     (conv2_switch_mode),
    .conv2_output_en       (conv2_output_en),
    .conv2_sleeping        (conv2_sleeping),
    .conv2_peak_low        (conv2_peak_low),
    .conv2_ramp            (conv2_ramp),
    .conv2_feedback_source (conv2_feedback_source),
    .sys_shutdown_req      (sys_shutdown_req),
    .conv3_ovp_en          (conv3_ovp_en),
    .conv3_discharge_en    (conv3_discharge_en),
    .conv3_voltage_code    (conv3_voltage_code),
    .irq                   (irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Tasks, all entered just after a rising edge

  // Verdict and end of run
  task finish_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One APB transfer; trailing idle edge keeps psel from two writes per step
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
            output logic [32:0] q);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Wait for the answer; only the watchdog ends a hung wait
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    q = {pslverr, prdata};
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [32:0] q;
    xfer(a, 1'b1, d, q);
  endtask

  // Read and compare error flag with data
  task rd_chk(input string nm, input logic [11:0] a, input logic [32:0] e);
    logic [32:0] q;
    xfer(a, 1'b0, 32'h0, q);
    `CHK(nm, e, q)
  endtask

  // Sequencer event: 0 slot strobe, 1 enter active, 2 enter off
  task seq_pulse(input int k, input logic [3:0] s);
    seq_slot_stb     <= (k == 0);
    seq_enter_active <= (k == 1);
    seq_enter_off    <= (k == 2);
    seq_slot         <= s;
    @(posedge core_clk);
    seq_slot_stb     <= 1'b0;
    seq_enter_active <= 1'b0;
    seq_enter_off    <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  task sm_pulse;
    sm_reset <= 1'b1;
    @(posedge core_clk);
    sm_reset <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  task fault_rise;
    conv2_fault_pin <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog; the run needs well under a thousand cycles
  always #2 core_clk = ~core_clk;

  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    core_clk = 0; arst_n = 0; clk_en = 1; sm_reset = 0; psel = 0; penable = 0;
    pwrite = 0; paddr = '0; pwdata = '0; lp = '0; gpio_sleep_pin = 0;
    conv2_fault_pin = 0; seq_slot_stb = 0; seq_slot = '0;
    seq_enter_active = 0; seq_enter_off = 0;
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    // Defaults and refused addresses
    `CHK("ramp rst", 2'h3, conv2_ramp)
    rd_chk("c2ctl rst", A_C2CTL, 33'h18);
    rd_chk("c2seq rst", A_C2SEQ, 33'h0);
    rd_chk("c3ctl rst", A_C3CTL, 33'h0);
    rd_chk("unmapped", 12'h010, {1'b1, 32'h0});
    rd_chk("misaligned", 12'h2dd, {1'b1, 32'h0});
    // All ones: read-only bits stay zero, voltage clamps at the cap
    wr(A_C2CTL, 32'hffff_ffff);
    wr(A_C2SEQ, 32'hffff_ffff);
    wr(A_C3CTL, 32'hffff_ffff);
    rd_chk("c2ctl ones", A_C2CTL, 33'h535b);
    rd_chk("c2seq ones", A_C2SEQ, 33'hffc0);
    rd_chk("c3ctl ones", A_C3CTL, 33'h0c7f);
    `CHK("topology", 1'b1, conv2_switch_mode)
    `CHK("peak", 1'b1, conv2_peak_low)
    `CHK("ovp", 1'b0, conv3_ovp_en)
    `CHK("discharge", 1'b0, conv3_discharge_en)
    `CHK("vcap", 7'h66, conv3_voltage_code)
    // Power state machine reset brings defaults back
    sm_pulse();
    rd_chk("c3ctl sm", A_C3CTL, 33'h0);
    `CHK("topology sm", 1'b0, conv2_switch_mode)
    `CHK("ovp sm", 1'b1, conv3_ovp_en)
    `CHK("discharge sm", 1'b1, conv3_discharge_en)
    `CHK("peak sm", 1'b0, conv2_peak_low)
    wr(A_C3CTL, 32'h0000_0066);
    repeat (2) @(posedge core_clk);
    `CHK("vmax", 7'h66, conv3_voltage_code)
    wr(A_C3CTL, 32'h0000_0026);
    repeat (2) @(posedge core_clk);
    `CHK("vmid", 7'h26, conv3_voltage_code)
    // Every ramp code against every feedback code
    for (r = 0; r < 4; r++) begin
      for (f = 0; f < 4; f++) begin
        wr(A_C2CTL, 32'((r << 3) | f));
        repeat (2) @(posedge core_clk);
        er = (f == 3) ? 2'h3 : 2'(r);
        `CHK("ramp", er, conv2_ramp)
        `CHK("feedback", 2'(f), conv2_feedback_source)
      end
    end
    // Slot boundaries: start in 14, stop in 1
    wr(A_C2SEQ, 32'h3840);
    seq_pulse(0, 4'hd);
    `CHK("slot 13", 1'b0, conv2_output_en)
    seq_pulse(0, 4'he);
    `CHK("slot 14", 1'b1, conv2_output_en)
    seq_pulse(0, 4'h2);
    `CHK("slot 2", 1'b1, conv2_output_en)
    seq_pulse(0, 4'h1);
    `CHK("slot 1", 1'b0, conv2_output_en)
    wr(A_C2SEQ, 32'h3c00);
    seq_pulse(1, 4'h0);
    `CHK("on active", 1'b1, conv2_output_en)
    seq_pulse(2, 4'h0);
    `CHK("off code 0", 1'b0, conv2_output_en)
    wr(A_C2SEQ, 32'h3fc0);
    seq_pulse(1, 4'h0);
    seq_pulse(2, 4'h0);
    `CHK("off code 15", 1'b0, conv2_output_en)
    wr(A_C2SEQ, 32'h0000);
    seq_pulse(1, 4'h0);
    `CHK("never", 1'b0, conv2_output_en)
    // Hibernate trigger sources, other low-power inputs held high first
    wr(A_C2SEQ, 32'h3c00);
    seq_pulse(1, 4'h0);
    for (r = 0; r < 4; r++) begin
      wr(A_C2CTL, 32'h1018 | (r << 8));
      lp <= (r == 0) ? 3'b111 : ~(3'b001 << (r - 1));
      repeat (6) @(posedge core_clk);
      `CHK("sleep other", 1'b0, conv2_sleeping)
      if (r == 0) wr(A_SLEEP, 32'h1);
      else lp <= 3'b111;
      repeat (6) @(posedge core_clk);
      `CHK("sleep sel", 1'b1, conv2_sleeping)
      `CHK("sleep off", 1'b0, conv2_output_en)
      lp <= 3'b000;
      wr(A_SLEEP, 32'h0);
      repeat (6) @(posedge core_clk);
      `CHK("awake", 1'b1, conv2_output_en)
    end
    wr(A_C2CTL, 32'h0118);
    lp <= 3'b001;
    repeat (6) @(posedge core_clk);
    `CHK("sleep run", 1'b1, conv2_output_en)
    lp <= 3'b000;
    wr(A_C2CTL, 32'h1118);
    gpio_sleep_pin <= 1'b1;
    repeat (6) @(posedge core_clk);
    `CHK("gpio sleep", 1'b1, conv2_sleeping)
    `CHK("gpio off", 1'b0, conv2_output_en)
    gpio_sleep_pin <= 1'b0;
    repeat (6) @(posedge core_clk);
    // Faults: ignore, masked interrupt, then the shutdown actions
    wr(A_MASK, 32'h0);
    rd_chk("stat sleep", A_STAT, 33'h2);
    fault_rise();
    `CHK("ignore", 1'b1, conv2_output_en)
    `CHK("masked", 1'b0, irq)
    wr(A_MASK, 32'h1);
    repeat (2) @(posedge core_clk);
    `CHK("irq", 1'b1, irq)
    rd_chk("stat fault", A_STAT, 33'h1);
    repeat (2) @(posedge core_clk);
    `CHK("irq clr", 1'b0, irq)
    conv2_fault_pin <= 1'b0;
    wr(A_C2SEQ, 32'h7c00);
    fault_rise();
    `CHK("conv down", 1'b0, conv2_output_en)
    `CHK("no sys", 1'b0, sys_shutdown_req)
    `CHK("irq 01", 1'b1, irq)
    conv2_fault_pin <= 1'b0;
    wr(A_C2SEQ, 32'hbc00);
    fault_rise();
    `CHK("sys 10", 1'b1, sys_shutdown_req)
    seq_pulse(2, 4'h0);
    `CHK("sys off", 1'b0, sys_shutdown_req)
    conv2_fault_pin <= 1'b0;
    wr(A_C2SEQ, 32'hfc00);
    fault_rise();
    `CHK("sys 11", 1'b1, sys_shutdown_req)
    sm_pulse();
    `CHK("sys sm", 1'b0, sys_shutdown_req)
    rd_chk("c2seq sm", A_C2SEQ, 33'h0);
    finish_test();
  end

endmodule

`default_nettype wire
